/* src/smc_pkg.sv */
package smc_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int OSC_HZ = 4_000_000;
   localparam int OSC_DIV = CLK_HZ / OSC_HZ;
   localparam int STRAP_OSC_PERIODS = 4;
   localparam int COPY_TIME_US = 340;
   localparam int COPY_CYCLES = (CLK_HZ / 1_000_000) * COPY_TIME_US;
   localparam int EXT_DIV = 4;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CLK_SRC = 8'h80;
   localparam logic [7:0] OFS_MOD_FREQ = 8'h85;
   localparam logic [7:0] OFS_ILLUM_CFG = 8'h90;
   localparam logic [7:0] OFS_INT_LEN_HI = 8'hA0;
   localparam logic [7:0] OFS_INT_LEN_LO = 8'hA1;
   localparam logic [7:0] OFS_INT_REP_HI = 8'hA2;
   localparam logic [7:0] OFS_INT_REP_LO = 8'hA3;
   localparam logic [7:0] OFS_DLY_EN = 8'hAE;
   localparam logic [7:0] OFS_DLY_CAL = 8'hE9;
   localparam logic [7:0] OFS_DLY_STEPS = 8'h73;
   // ---------------------------------------------------------------
   // fields and reset values
   // ---------------------------------------------------------------
   localparam int CLK_SRC_EXT_BIT = 6;
   localparam int LED_POL_BIT = 0;
   localparam int DLY_EN_BIT = 0;
   localparam logic [7:0] RST_CLK_SRC = 8'h00;
   localparam logic [7:0] RST_MOD_FREQ = 8'h01;
   localparam logic [7:0] RST_ILLUM_CFG = 8'h00;
   localparam logic [7:0] RST_INT_LEN = 8'h00;
   localparam logic [7:0] RST_INT_REP = 8'h00;
   localparam logic [7:0] RST_DLY_EN = 8'h00;
   localparam logic [7:0] RST_DLY_STEPS = 8'h00;
   localparam logic [7:0] RST_DLY_CAL = 8'h00;
   // ---------------------------------------------------------------
   // strap pin indices and copy table
   // ---------------------------------------------------------------
   localparam int PIN_LINE_SYNC_ADDR_BIT1 = 0;
   localparam int PIN_FRAME_SYNC_ADDR_BIT0 = 1;
   localparam int PIN_SATURATION_FLAG = 2;
   localparam int PIN_PIXEL_BUS_BIT0 = 3;
   localparam int NV_COPY_N = 4;
   localparam logic [6:0] NV_ADDR_MOD_FREQ = 7'h00;
   localparam logic [6:0] NV_ADDR_ILLUM_CFG = 7'h01;
   localparam logic [6:0] NV_ADDR_DLY_STEPS = 7'h02;
   localparam logic [6:0] NV_ADDR_DLY_CAL = 7'h03;
   localparam logic [6:0] I2C_ADDR_BASE = 7'h20;

   typedef enum logic [2:0] {
      ST_STRAP = 3'b001,
      ST_COPY = 3'b010,
      ST_RUN = 3'b100
   } smc_state_t;
endpackage

/* src/smc_dly_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface smc_dly_if;
   logic mod_in;
   logic en;
   logic [7:0] steps;
   logic mod_out;
   modport src (output mod_in, output en, output steps, input mod_out);
   modport line (input mod_in, input en, input steps, output mod_out);
endinterface
`default_nettype wire

/* src/smc_delay_line.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_delay_line #(
   parameter int DEPTH = 256
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   smc_dly_if.line dly
);
   typedef struct packed {
      logic [DEPTH-1:0] sh;
      logic out;
   } smc_dly_st_t;

   smc_dly_st_t st_q;
   smc_dly_st_t st_d;

   assign dly.mod_out = st_q.out;

   // one step is one clock cycle; finer steps need an analog line
   always_comb begin
      st_d = st_q;
      st_d.sh = {st_q.sh[DEPTH-2:0], dly.mod_in};
      if (dly.en && dly.steps != 8'h00) begin
         st_d.out = st_q.sh[dly.steps - 8'h01];
      end else begin
         st_d.out = dly.mod_in;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   chk_dly_bypass: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      !dly.en |=> dly.mod_out == $past(dly.mod_in))
      else $error("bypassed delay line did not pass source");
   chk_dly_one_step: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      (dly.en && dly.steps == 8'h01) ##1 (dly.en && dly.steps == 8'h01)
      |=> dly.mod_out == $past(dly.mod_in, 2))
      else $error("one delay step not two cycles");
endmodule
`default_nettype wire

/* src/smc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module smc_top #(
   parameter int COPY_CYCLES = smc_pkg::COPY_CYCLES,
   parameter logic [7:0] CAL_DEFAULT = 8'h5A // arbitrary value
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   output logic [6:0] nv_addr_out,
   output logic nv_rd_out,
   input wire logic [7:0] nv_data_in,
   output logic copy_done_out,
   output logic pll_start_out,
   output logic pll_ready_out,
   input wire logic [3:0] strap_pin_in,
   input wire logic [3:0] pin_func_in,
   output logic [3:0] strap_pin_out,
   output logic [3:0] strap_pin_oe_out,
   output logic [3:0] strap_pulldown_out,
   output logic [6:0] i2c_addr_out,
   input wire logic ext_mod_clock_in,
   input wire logic acq_start_in,
   output logic integrating_out,
   output logic demod_mod_out,
   output logic led_mod_out
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      smc_pkg::smc_state_t state;
      logic [3:0] osc_cnt;
      logic [2:0] strap_ticks;
      logic [15:0] timer;
      logic [2:0] copy_idx;
      logic copy_pend;
      logic [3:0] straps;
      logic [7:0] clk_src;
      logic [7:0] mod_freq;
      logic [7:0] illum_cfg;
      logic [15:0] int_len;
      logic [15:0] int_rep;
      logic [7:0] dly_en;
      logic [7:0] dly_steps;
      logic [7:0] dly_cal;
      logic [7:0] rdata;
      logic rvalid;
      logic [6:0] nv_addr;
      logic nv_rd;
      logic copy_done;
      logic pll_start;
      logic ext_prev;
      logic [1:0] ext_div;
      logic [7:0] int_cnt;
      logic int_mod;
      logic demod;
      logic integ;
      logic [32:0] integ_cnt;
      logic [3:0] pin_out;
      logic [3:0] pin_oe;
      logic [3:0] pull_dn;
   } smc_st_t;

   smc_st_t st_q;
   smc_st_t st_d;
   smc_dly_if dly_bus ();

   logic osc_tick;
   logic ext_rise;
   logic ext_sel;
   logic mod_src;
   logic base_tick;
   logic [32:0] integ_target;

   assign osc_tick = st_q.osc_cnt == 4'(smc_pkg::OSC_DIV - 1);
   assign ext_rise = ext_mod_clock_in && !st_q.ext_prev;
   assign ext_sel = st_q.clk_src[smc_pkg::CLK_SRC_EXT_BIT];
   // internal source ticks once per clock cycle in place of a period
   assign base_tick = ext_sel ? ext_rise : 1'b1;
   assign mod_src = ext_sel ? st_q.ext_div[1] : st_q.int_mod;
   assign integ_target = 33'({17'd0, st_q.int_rep} + 33'd1)
      * 33'({17'd0, st_q.int_len});

   assign dly_bus.mod_in = mod_src
      ^ st_q.illum_cfg[smc_pkg::LED_POL_BIT];
   assign dly_bus.en = st_q.dly_en[smc_pkg::DLY_EN_BIT];
   assign dly_bus.steps = st_q.dly_steps;

   smc_delay_line #(
      .DEPTH(256)
   ) u_dly (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .dly(dly_bus.line)
   );

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata_out = st_q.rdata;
   assign reg_rvalid_out = st_q.rvalid;
   assign nv_addr_out = st_q.nv_addr;
   assign nv_rd_out = st_q.nv_rd;
   assign copy_done_out = st_q.copy_done;
   assign pll_start_out = st_q.pll_start;
   assign pll_ready_out = st_q.copy_done;
   assign strap_pin_out = st_q.pin_out;
   assign strap_pin_oe_out = st_q.pin_oe;
   assign strap_pulldown_out = st_q.pull_dn;
   assign i2c_addr_out = {smc_pkg::I2C_ADDR_BASE[6:2],
      st_q.straps[smc_pkg::PIN_LINE_SYNC_ADDR_BIT1],
      st_q.straps[smc_pkg::PIN_FRAME_SYNC_ADDR_BIT0]};
   assign integrating_out = st_q.integ;
   assign demod_mod_out = st_q.demod;
   assign led_mod_out = dly_bus.mod_out;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.rvalid = 1'b0;
      st_d.nv_rd = 1'b0;
      st_d.osc_cnt = osc_tick ? 4'h0 : st_q.osc_cnt + 4'h1;
      // timer runs from release so copy and straps share one origin
      if (st_q.timer != 16'(COPY_CYCLES)) begin
         st_d.timer = st_q.timer + 16'h0001;
      end

      unique case (st_q.state)
         smc_pkg::ST_STRAP: begin
            st_d.pin_oe = 4'h0;
            st_d.pull_dn = 4'hF;
            if (osc_tick) begin
               st_d.strap_ticks = st_q.strap_ticks + 3'h1;
               if (st_q.strap_ticks ==
                  3'(smc_pkg::STRAP_OSC_PERIODS - 1)) begin
                  st_d.straps = strap_pin_in;
                  st_d.pull_dn = 4'h0;
                  st_d.pin_oe = 4'hF;
                  st_d.state = smc_pkg::ST_COPY;
               end
            end
         end
         smc_pkg::ST_COPY: begin
            // copy is paced by the 4 MHz tick while the PLL locks
            if (st_q.copy_pend) begin
               st_d.copy_pend = 1'b0;
               unique case (st_q.nv_addr)
                  smc_pkg::NV_ADDR_MOD_FREQ: st_d.mod_freq = nv_data_in;
                  smc_pkg::NV_ADDR_ILLUM_CFG: st_d.illum_cfg = nv_data_in;
                  smc_pkg::NV_ADDR_DLY_STEPS: st_d.dly_steps = nv_data_in;
                  default: st_d.dly_cal = nv_data_in;
               endcase
            end else if (osc_tick &&
               st_q.copy_idx != 3'(smc_pkg::NV_COPY_N)) begin
               st_d.nv_addr = 7'(st_q.copy_idx);
               st_d.nv_rd = 1'b1;
               st_d.copy_pend = 1'b1;
               st_d.copy_idx = st_q.copy_idx + 3'h1;
            end
            if (st_q.timer == 16'(COPY_CYCLES - 1)) begin
               st_d.copy_done = 1'b1;
               st_d.pll_start = 1'b0;
               st_d.state = smc_pkg::ST_RUN;
            end
         end
         smc_pkg::ST_RUN: begin
            if (acq_start_in && !st_q.integ) begin
               st_d.integ = integ_target != 33'd0;
               st_d.integ_cnt = '0;
            end else if (st_q.integ && base_tick) begin
               st_d.integ_cnt = st_q.integ_cnt + 33'd1;
               if (st_q.integ_cnt + 33'd1 == integ_target) begin
                  st_d.integ = 1'b0;
               end
            end
         end
         default: st_d.state = smc_pkg::ST_STRAP;
      endcase

      // normal pin function once sampling is over
      st_d.pin_out = pin_func_in;

      // modulation sources
      st_d.ext_prev = ext_mod_clock_in;
      if (ext_rise) begin
         st_d.ext_div = st_q.ext_div + 2'h1;
      end
      // >= lets a smaller setting take hold without an 8-bit wrap
      if (st_q.int_cnt >= st_q.mod_freq) begin
         st_d.int_cnt = 8'h00;
         st_d.int_mod = !st_q.int_mod;
      end else begin
         st_d.int_cnt = st_q.int_cnt + 8'h01;
      end
      st_d.demod = mod_src;

      // register port
      if (reg_wr_in) begin
         unique case (reg_addr_in)
            smc_pkg::OFS_CLK_SRC: st_d.clk_src = reg_wdata_in;
            smc_pkg::OFS_MOD_FREQ: st_d.mod_freq = reg_wdata_in;
            smc_pkg::OFS_ILLUM_CFG: st_d.illum_cfg = reg_wdata_in;
            smc_pkg::OFS_INT_LEN_HI: st_d.int_len[15:8] = reg_wdata_in;
            smc_pkg::OFS_INT_LEN_LO: st_d.int_len[7:0] = reg_wdata_in;
            smc_pkg::OFS_INT_REP_HI: st_d.int_rep[15:8] = reg_wdata_in;
            smc_pkg::OFS_INT_REP_LO: st_d.int_rep[7:0] = reg_wdata_in;
            smc_pkg::OFS_DLY_EN: st_d.dly_en = reg_wdata_in;
            smc_pkg::OFS_DLY_STEPS: st_d.dly_steps = reg_wdata_in;
            default: begin
            end
         endcase
      end
      if (reg_rd_in) begin
         st_d.rvalid = 1'b1;
         unique case (reg_addr_in)
            smc_pkg::OFS_CLK_SRC: st_d.rdata = st_q.clk_src;
            smc_pkg::OFS_MOD_FREQ: st_d.rdata = st_q.mod_freq;
            smc_pkg::OFS_ILLUM_CFG: st_d.rdata = st_q.illum_cfg;
            smc_pkg::OFS_INT_LEN_HI: st_d.rdata = st_q.int_len[15:8];
            smc_pkg::OFS_INT_LEN_LO: st_d.rdata = st_q.int_len[7:0];
            smc_pkg::OFS_INT_REP_HI: st_d.rdata = st_q.int_rep[15:8];
            smc_pkg::OFS_INT_REP_LO: st_d.rdata = st_q.int_rep[7:0];
            smc_pkg::OFS_DLY_EN: st_d.rdata = st_q.dly_en;
            smc_pkg::OFS_DLY_STEPS: st_d.rdata = st_q.dly_steps;
            smc_pkg::OFS_DLY_CAL: st_d.rdata = st_q.dly_cal;
            default: st_d.rdata = 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q <= '0;
         st_q.state <= smc_pkg::ST_STRAP;
         st_q.clk_src <= smc_pkg::RST_CLK_SRC;
         st_q.mod_freq <= smc_pkg::RST_MOD_FREQ;
         st_q.illum_cfg <= smc_pkg::RST_ILLUM_CFG;
         st_q.int_len <= {smc_pkg::RST_INT_LEN, smc_pkg::RST_INT_LEN};
         st_q.int_rep <= {smc_pkg::RST_INT_REP, smc_pkg::RST_INT_REP};
         st_q.dly_en <= smc_pkg::RST_DLY_EN;
         st_q.dly_steps <= smc_pkg::RST_DLY_STEPS;
         st_q.dly_cal <= CAL_DEFAULT;
         st_q.pll_start <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_strap_inputs: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      st_q.state == smc_pkg::ST_STRAP && st_q.timer > 16'h0000
      |-> strap_pin_oe_out == 4'h0 && strap_pulldown_out == 4'hF)
      else $error("strap pins not inputs with pull-down");
   chk_strap_window: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      $fell(st_q.state == smc_pkg::ST_STRAP)
      |-> st_q.timer == 16'(smc_pkg::OSC_DIV * smc_pkg::STRAP_OSC_PERIODS))
      else $error("strap window not four oscillator periods");
   chk_strap_outputs: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      st_q.state != smc_pkg::ST_STRAP
      |-> strap_pin_oe_out == 4'hF && strap_pulldown_out == 4'h0)
      else $error("strap pins not back to outputs");
   chk_strap_latch: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      $fell(st_q.state == smc_pkg::ST_STRAP)
      |-> i2c_addr_out[1:0] == {$past(strap_pin_in[0]),
         $past(strap_pin_in[1])})
      else $error("strap level not latched into address");
   chk_strap_once: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      st_q.state != smc_pkg::ST_STRAP
      && $past(st_q.state) != smc_pkg::ST_STRAP
      |-> $stable(st_q.straps))
      else $error("strap levels sampled more than once");
   chk_copy_time: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      $rose(copy_done_out) |-> st_q.timer == 16'(COPY_CYCLES))
      else $error("copy not finished at its time");
   chk_copy_held: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      copy_done_out |=> copy_done_out)
      else $error("copy done dropped before reset");
   chk_copy_all: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      copy_done_out |-> st_q.copy_idx == 3'(smc_pkg::NV_COPY_N)
      && !st_q.copy_pend)
      else $error("copy finished with words left over");
   chk_copy_pll: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      nv_rd_out |-> pll_start_out && !pll_ready_out)
      else $error("copy not alongside PLL start");
   chk_copy_pulse: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      nv_rd_out |=> !nv_rd_out)
      else $error("nonvolatile read longer than one cycle");
   chk_pll_phase: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      pll_start_out == !copy_done_out)
      else $error("PLL start phase and copy out of step");
   chk_ext_select: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      ext_sel && $stable(ext_sel)
      |-> demod_mod_out == $past(st_q.ext_div[1]))
      else $error("external source not used");
   chk_int_select: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      !ext_sel && $stable(ext_sel)
      |-> demod_mod_out == $past(st_q.int_mod))
      else $error("internal source not used");
   chk_ext_div_four: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      !ext_rise |=> $stable(st_q.ext_div))
      else $error("external divider moved without edge");
   chk_ext_div_step: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      ext_rise |=> st_q.ext_div == $past(st_q.ext_div) + 2'h1)
      else $error("external divider missed an edge");
   chk_led_source: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      !dly_bus.en |=> led_mod_out
      == (demod_mod_out ^ $past(st_q.illum_cfg[smc_pkg::LED_POL_BIT])))
      else $error("LED and demodulator not from one source");
   chk_integ_count: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      $fell(integrating_out) |-> st_q.integ_cnt == $past(integ_target))
      else $error("integration length wrong");
   chk_integ_run: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      st_q.state != smc_pkg::ST_RUN |-> !integrating_out)
      else $error("integration outside run state");
   chk_cal_readonly: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      st_q.state == smc_pkg::ST_RUN |=> $stable(st_q.dly_cal))
      else $error("calibration value changed after copy");
   chk_steps_write: assert property (
      @(posedge clk_in) disable iff (!nrst_in)
      reg_wr_in && reg_addr_in == smc_pkg::OFS_DLY_STEPS
      |=> st_q.dly_steps == $past(reg_wdata_in))
      else $error("delay step count not written");
endmodule
`default_nettype wire

/* testbench/smc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// far side: nonvolatile store, board straps and
// external modulation source
// ---------------------------------------------
module smc_far_model (
   input wire logic clk_in,
   input wire logic [1:0] pullup_in,
   input wire logic ext_en_in,
   input wire logic [6:0] nv_addr_in,
   input wire logic nv_rd_in,
   output logic [7:0] nv_data_out,
   input wire logic [3:0] oe_in,
   input wire logic [3:0] drv_in,
   input wire logic [3:0] pd_in,
   output logic [3:0] pin_out,
   output logic ext_clk_out
);
   logic [7:0] mem [4];
   logic rd_q = 1'b0;
   logic [3:0] noise = 4'h5;
   logic [1:0] ph = 2'h0;
   logic [3:0] pu;
   logic ext_q = 1'b0;
   initial begin
      mem = '{8'h33, 8'h01, 8'h05, 8'hC7};
   end
   assign ext_clk_out = ext_q;
   // factory straps never get a board pull-up
   assign pu = {2'b00, pullup_in};
   always @(posedge clk_in) begin
      rd_q <= nv_rd_in;
      noise <= ~noise;
      ph <= ext_en_in ? ph + 2'h1 : 2'h0;
      // slow square wave, well under the input limit; stands at 0 when off
      ext_q <= #2 ext_en_in & ph[1];
   end
   // data held over the read cycle and the next, junk otherwise
   always_comb begin
      if (nv_rd_in | rd_q)
         nv_data_out = mem[nv_addr_in[1:0]];
      else
         nv_data_out = {noise, ~noise};
   end
   // an undriven pin with no pull shows a changing pattern, never a hold
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (oe_in[i])
            pin_out[i] = drv_in[i];
         else if (pu[i])
            pin_out[i] = 1'b1;
         else if (pd_in[i])
            pin_out[i] = 1'b0;
         else
            pin_out[i] = noise[i];
      end
   end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int CPY = 200;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic acq = 1'b0;
   logic ext_en = 1'b0;
   logic [3:0] func = 4'hA;
   logic [1:0] pu = 2'b01;
   logic [7:0] rdata, nv_data;
   logic rvalid, nv_rd, copy_done, pll_start, pll_ready;
   logic integ, demod, led, ext_clk;
   logic [6:0] nv_addr, i2c;
   logic [3:0] pin, pin_out, oe, pd;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int rel = 0;
   initial begin
      forever #12.5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) cyc <= cyc + 1;
   smc_top #(.COPY_CYCLES(CPY)) dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .nv_addr_out(nv_addr), .nv_rd_out(nv_rd), .nv_data_in(nv_data),
      .copy_done_out(copy_done), .pll_start_out(pll_start),
      .pll_ready_out(pll_ready), .strap_pin_in(pin), .pin_func_in(func),
      .strap_pin_out(pin_out), .strap_pin_oe_out(oe),
      .strap_pulldown_out(pd), .i2c_addr_out(i2c),
      .ext_mod_clock_in(ext_clk), .acq_start_in(acq),
      .integrating_out(integ), .demod_mod_out(demod), .led_mod_out(led));
   smc_far_model far_u (.clk_in(clk_in), .pullup_in(pu), .ext_en_in(ext_en),
      .nv_addr_in(nv_addr), .nv_rd_in(nv_rd), .nv_data_out(nv_data),
      .oe_in(oe), .drv_in(pin_out), .pd_in(pd), .pin_out(pin),
      .ext_clk_out(ext_clk));
   // ---------------------------------------------
   // shared tasks
   // ---------------------------------------------
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // drive and sample at one fixed offset after the edge
   task automatic tick;
      @(posedge clk_in);
      #2;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      tick;
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick;
      wr = 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      tick;
      addr = a;
      rd = 1'b1;
      tick;
      rd = 1'b0;
      check("read valid", {15'h0, rvalid}, 16'h0001);
      check($sformatf("reg %h", a), {8'h00, rdata}, {8'h00, exp});
   endtask
   task automatic gap(output int n);
      logic p;
      tick;
      p = demod;
      n = 0;
      while (demod === p && n < 100) begin
         tick;
         n++;
      end
      p = demod;
      n = 0;
      while (demod === p && n < 100) begin
         tick;
         n++;
      end
   endtask
   task automatic integ_len(output int n);
      n = 0;
      tick;
      acq = 1'b1;
      tick;
      acq = 1'b0;
      while (integ === 1'b1 && n < 500) begin
         tick;
         n++;
      end
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_startup(input logic [1:0] p);
      int n;
      pu = p;
      nrst_in = 1'b0;
      repeat (20) tick;
      check("oe in reset", {12'h0, oe}, 16'h0000);
      check("pd in reset", {12'h0, pd}, 16'h0000);
      check("pll start", {15'h0, pll_start}, 16'h0001);
      check("addr in reset", {9'h0, i2c}, 16'h0020);
      nrst_in = 1'b1;
      rel = cyc;
      tick;
      check("pd strap", {12'h0, pd}, 16'h000F);
      check("oe strap", {12'h0, oe}, 16'h0000);
      rchk(8'h85, 8'h01);
      n = 0;
      while (oe !== 4'hF && n < 60) begin
         tick;
         n++;
      end
      check("strap span", {15'h0, (cyc - rel) inside {[40:42]}}, 16'h1);
      check("pd after", {12'h0, pd}, 16'h0000);
      check("addr", {9'h0, i2c}, {9'h0, 5'b01000, p[0], p[1]});
      tick;
      check("pin drive", {12'h0, pin_out}, {12'h0, func});
      while (copy_done !== 1'b1 && n < 400) begin
         tick;
         n++;
      end
      check("copy span", {15'h0, (cyc - rel) inside {[CPY:CPY+2]}}, 16'h1);
      check("pll start end", {15'h0, pll_start}, 16'h0000);
      check("pll ready", {15'h0, pll_ready}, 16'h0001);
      rchk(8'h85, 8'h33);
      rchk(8'h90, 8'h01);
      rchk(8'h73, 8'h05);
      rchk(8'hE9, 8'hC7);
      rchk(8'h80, 8'h00);
   endtask
   task automatic t_regs;
      wr_reg(8'hE9, 8'h00);
      rchk(8'hE9, 8'hC7);
      rchk(8'h10, 8'h00);
      for (int i = 0; i < 4; i++) wr_reg(8'hA0 + i[7:0], 8'h11 * i[7:0]);
      for (int i = 0; i < 4; i++) rchk(8'hA0 + i[7:0], 8'h11 * i[7:0]);
   endtask
   task automatic t_mod;
      int n;
      logic [7:0] h;
      h = 8'h00;
      wr_reg(8'h90, 8'h00);
      wr_reg(8'hAE, 8'h00);
      wr_reg(8'h85, 8'h04);
      gap(n);
      check("int gap", n[15:0], 16'd5);
      repeat (12) begin
         tick;
         check("led same", {15'h0, led}, {15'h0, demod});
      end
      wr_reg(8'h90, 8'h01);
      repeat (12) begin
         tick;
         check("led inv", {15'h0, led}, {15'h0, ~demod});
      end
      wr_reg(8'h90, 8'h00);
      wr_reg(8'h73, 8'h03);
      wr_reg(8'hAE, 8'h01);
      for (int i = 0; i < 24; i++) begin
         tick;
         h = {h[6:0], demod};
         if (i > 8) check("led delay", {15'h0, led}, {15'h0, h[3]});
      end
      wr_reg(8'h73, 8'h01);
      for (int i = 0; i < 12; i++) begin
         tick;
         h = {h[6:0], demod};
         if (i > 4) check("led one step", {15'h0, led}, {15'h0, h[1]});
      end
      wr_reg(8'hAE, 8'h00);
      ext_en = 1'b1;
      wr_reg(8'h80, 8'h40);
      wr_reg(8'h85, 8'h02);
      gap(n);
      gap(n);
      check("ext gap", n[15:0], 16'd8);
      tick;
      check("ext led", {15'h0, led}, {15'h0, demod});
   endtask
   task automatic t_integ;
      int n;
      wr_reg(8'h80, 8'h00);
      wr_reg(8'hA0, 8'h00);
      wr_reg(8'hA2, 8'h00);
      wr_reg(8'hA1, 8'h03);
      wr_reg(8'hA3, 8'h01);
      integ_len(n);
      check("int len", {15'h0, n inside {[5:7]}}, 16'h1);
      wr_reg(8'hA1, 8'h00);
      integ_len(n);
      check("zero len", n[15:0], 16'd0);
      wr_reg(8'hA1, 8'h03);
      wr_reg(8'h80, 8'h40);
      integ_len(n);
      check("ext len", {15'h0, n inside {[20:28]}}, 16'h1);
      ext_en = 1'b0;
   endtask
   initial begin
      #200_000;
      err_count++;
      stop_test;
   end
   initial begin
      t_startup(2'b01);
      t_regs;
      t_mod;
      t_integ;
      t_startup(2'b10);
      stop_test;
   end
endmodule
`default_nettype wire
